// File: common/pio_pkg.sv
package pio_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_ARG_LO  = 8'h04;
	localparam logic [7:0] ADDR_ARG_HI  = 8'h08;
	localparam logic [7:0] ADDR_RESP_LO = 8'h0c;
	localparam logic [7:0] ADDR_RESP_HI = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_CTRL    = 8'h18;
	// control register bit positions
	localparam int CTRL_ALLOC_BIT  = 0;
	localparam int CTRL_DELETE_BIT = 1;
	// connection states
	typedef enum logic [2:0] {
		ST_NONEXIST = 3'b000,
		ST_CONFIG   = 3'b001,
		ST_WAIT_ID  = 3'b010,
		ST_ESTAB    = 3'b011,
		ST_TIMEDOUT = 3'b100,
		ST_DEFERRED = 3'b101
	} pio_state_t;
	// service codes
	localparam logic [7:0] SVC_RESET = 8'h05;
	localparam logic [7:0] SVC_GET   = 8'h0e;
	localparam logic [7:0] SVC_SET   = 8'h10;
	// attribute ids
	localparam logic [7:0] AT_STATE    = 8'h01;
	localparam logic [7:0] AT_TYPE     = 8'h02;
	localparam logic [7:0] AT_TCT      = 8'h03;
	localparam logic [7:0] AT_PROD_ID  = 8'h04;
	localparam logic [7:0] AT_CONS_ID  = 8'h05;
	localparam logic [7:0] AT_ICC      = 8'h06;
	localparam logic [7:0] AT_PSIZE    = 8'h07;
	localparam logic [7:0] AT_CSIZE    = 8'h08;
	localparam logic [7:0] AT_INTERVAL = 8'h09;
	localparam logic [7:0] AT_WDT      = 8'h0c;
	localparam logic [7:0] AT_PLEN     = 8'h0d;
	localparam logic [7:0] AT_PPATH    = 8'h0e;
	localparam logic [7:0] AT_CLEN     = 8'h0f;
	localparam logic [7:0] AT_CPATH    = 8'h10;
	// general status codes
	localparam logic [7:0] GS_SUCCESS   = 8'h00;
	localparam logic [7:0] GS_UNSUP     = 8'h08;
	localparam logic [7:0] GS_INVALID   = 8'h09;
	localparam logic [7:0] GS_CONFLICT  = 8'h0c;
	localparam logic [7:0] GS_NOT_SET   = 8'h0e;
	localparam logic [7:0] GS_ATTR_NONE = 8'h14;
	localparam logic [7:0] GS_NO_OBJ    = 8'h16;
	// instance numbers
	localparam logic [7:0] INST_CLASS = 8'h00;
	localparam logic [7:0] INST_POLL  = 8'h02;
	// reset values
	localparam logic [7:0]  TYPE_IO        = 8'h01;
	localparam logic [7:0]  TCT_RESET      = 8'h82;
	localparam logic [7:0]  ICC_RESET      = 8'h01;
	localparam logic [7:0]  WDT_RESET      = 8'h00;
	localparam logic [47:0] PPATH_RESET    = 48'h03_30_02_24_04_20;
	localparam logic [47:0] CPATH_RESET    = 48'h03_30_07_24_04_20;
	localparam logic [15:0] PATH_LEN       = 16'h0006;
	localparam logic [15:0] INTERVAL_RESET = 16'h0000;
	// timeout actions
	localparam logic [7:0] WDA_TIMEOUT  = 8'h00;
	localparam logic [7:0] WDA_DELETE   = 8'h01;
	localparam logic [7:0] WDA_RESTART  = 8'h02;
	localparam logic [7:0] WDA_DEFERRED = 8'h03;
	// transport class field
	localparam int            TCT_CLASS_LSB  = 0;
	localparam logic [3:0]    TCT_CLASS_RSVD = 4'h1;
	// timing: the interval attribute counts milliseconds
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS       = 1000000;
	localparam int CYC_PER_TICK  = TICK_NS / CLK_PERIOD_NS;
	// service request as written to the command register
	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] inst;
		logic [7:0] attr;
		logic [7:0] svc;
	} pio_cmd_t;
	// result of one service
	typedef struct packed {
		logic [7:0]  code;
		logic [7:0]  len;
		logic [47:0] data;
	} pio_resp_t;
endpackage

// File: dv/pio_master_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pio_master_model #(
	parameter int PER = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic poll_en,
	output logic      rx_activity
);
	int cnt;
	// one poll request every PER cycles while polling runs, silent otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			rx_activity <= 1'b0;
		end else begin
			cnt <= (poll_en && cnt < PER - 1) ? cnt + 1 : 0;
			rx_activity <= poll_en && cnt == 0;
		end
	end
endmodule
`default_nettype wire

// File: dv/polled_io_connection_object_tb.sv
`timescale 1ns/100ps
`default_nettype none
module polled_io_connection_object_tb;
	import pio_pkg::*;
	localparam int          TICK     = 4;
	localparam logic [15:0] PSZ      = 16'h0010;
	localparam logic [15:0] CSZ      = 16'h0008;
	localparam logic [47:0] NEW_PATH = 48'h05_30_09_24_04_20;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        conn_id_ready;
	logic        rx_activity;
	logic        poll_en;
	logic        guard;
	pio_state_t  conn_state;
	logic [3:0]  produce_group;
	logic [3:0]  consume_group;
	logic        watchdog_expired;
	logic [7:0]  code;
	logic [47:0] data;
	logic [31:0] q;
	logic        err;
	int          bad_count;
	int          n_tests;
////////////////////////////////////////////////////////////////////////////////
	pio_conn #(.CYC_PER_TICK(TICK)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conn_id_ready(conn_id_ready),
		.produced_conn_id(16'h03c1), .consumed_conn_id(16'h03c5),
		.produce_obj_size(PSZ), .consume_obj_size(CSZ),
		.rx_activity(rx_activity), .conn_state(conn_state),
		.produce_group(produce_group), .consume_group(consume_group),
		.watchdog_expired(watchdog_expired)
	);
	pio_master_model u_master (
		.pclk(pclk), .presetn(presetn), .poll_en(poll_en), .rx_activity(rx_activity)
	);
////////////////////////////////////////////////////////////////////////////////
	task automatic mis(input string m);
		bad_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			mis(m);
		end
	endtask
	task automatic chk_st(input pio_state_t exp);
		n_tests++;
		if (conn_state !== exp) begin
			mis("connection state");
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mis("no ready");
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic svc(input logic [7:0] s, input logic [7:0] i, input logic [7:0] a,
		input logic [47:0] arg);
		logic [31:0] lo;
		apb(1'b1, ADDR_ARG_LO, arg[31:0], q);
		apb(1'b1, ADDR_ARG_HI, {16'h0000, arg[47:32]}, q);
		apb(1'b1, ADDR_CMD, {8'h00, i, a, s}, q);
		apb(1'b0, ADDR_STATUS, 32'h0, q);
		code = q[15:8];
		apb(1'b0, ADDR_RESP_LO, 32'h0, lo);
		apb(1'b0, ADDR_RESP_HI, 32'h0, q);
		data = {q[15:0], lo};
	endtask
	task automatic get_attr(input logic [7:0] a, input logic [47:0] exp);
		svc(SVC_GET, INST_POLL, a, 48'h0);
		chk({40'h0, code}, {40'h0, GS_SUCCESS}, "get status");
		chk(data, exp, "get data");
	endtask
	task automatic put_attr(input logic [7:0] a, input logic [47:0] v, input logic [7:0] exp);
		svc(SVC_SET, INST_POLL, a, v);
		chk({40'h0, code}, {40'h0, exp}, "set status");
	endtask
	task automatic wait_exp();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (watchdog_expired !== 1'b1 && n < 200);
		chk({47'h0, watchdog_expired}, 48'h1, "watchdog expiry");
		repeat (3) @(posedge pclk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#50000;
		mis("timeout");
		stop_test();
	end
	always @(posedge pclk) begin
		if (guard && watchdog_expired === 1'b1) begin
			mis("expiry while polled");
		end
		if (conn_state === ST_DEFERRED) begin
			mis("deferred delete state");
		end
	end
	initial begin
		bad_count = 0;
		n_tests = 0;
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		conn_id_ready <= 1'b0;
		poll_en <= 1'b0;
		guard <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_st(ST_NONEXIST);
		svc(SVC_GET, INST_POLL, AT_STATE, 48'h0);
		chk({40'h0, code}, {40'h0, GS_NO_OBJ}, "get without instance");
		apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ALLOC_BIT, q);
		@(posedge pclk);
		chk_st(ST_CONFIG);
		chk({44'h0, produce_group}, 48'h0, "produce group");
		chk({44'h0, consume_group}, 48'h1, "consume group");
		get_attr(AT_STATE, 48'h1);
		get_attr(AT_ICC, {40'h0, ICC_RESET});
		get_attr(AT_TCT, 48'h82);
		get_attr(AT_WDT, 48'h0);
		get_attr(AT_PPATH, 48'h03_30_02_24_04_20);
		get_attr(AT_CPATH, 48'h03_30_07_24_04_20);
		get_attr(AT_PLEN, 48'h6);
		get_attr(AT_CLEN, 48'h6);
		get_attr(AT_PSIZE, {32'h0, PSZ});
		get_attr(AT_CSIZE, {32'h0, CSZ});
		get_attr(AT_PROD_ID, 48'h03c1);
		get_attr(AT_CONS_ID, 48'h03c5);
		get_attr(AT_TYPE, 48'h1);
		svc(SVC_GET, INST_CLASS, AT_STATE, 48'h0);
		chk({40'h0, code}, {40'h0, GS_UNSUP}, "class get");
		svc(SVC_RESET, INST_CLASS, 8'h00, 48'h0);
		chk({40'h0, code}, {40'h0, GS_UNSUP}, "class reset");
		put_attr(AT_WDT, 48'h3, GS_INVALID);
		put_attr(AT_TCT, 48'h81, GS_INVALID);
		put_attr(AT_TCT, 48'h83, GS_SUCCESS);
		get_attr(AT_TCT, 48'h83);
		put_attr(AT_PPATH, NEW_PATH, GS_SUCCESS);
		get_attr(AT_PPATH, NEW_PATH);
		put_attr(AT_PSIZE, {32'h0, PSZ + 16'h0001}, GS_INVALID);
		put_attr(AT_PSIZE, {32'h0, PSZ}, GS_SUCCESS);
		poll_en <= 1'b1;
		put_attr(AT_INTERVAL, 48'h2, GS_SUCCESS);
		chk_st(ST_WAIT_ID);
		get_attr(AT_INTERVAL, 48'h2);
		conn_id_ready <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_st(ST_ESTAB);
		guard <= 1'b1;
		put_attr(AT_PPATH, 48'h03_30_02_24_04_20, GS_CONFLICT);
		put_attr(AT_CPATH, 48'h03_30_02_24_04_20, GS_CONFLICT);
		put_attr(AT_TCT, 48'h82, GS_CONFLICT);
		guard <= 1'b0;
		poll_en <= 1'b0;
		wait_exp();
		chk_st(ST_TIMEDOUT);
		repeat (30) @(posedge pclk);
		chk_st(ST_TIMEDOUT);
		poll_en <= 1'b1;
		svc(SVC_RESET, INST_POLL, 8'h00, 48'h0);
		chk({40'h0, code}, {40'h0, GS_SUCCESS}, "reset service");
		chk_st(ST_ESTAB);
		put_attr(AT_WDT, 48'h2, GS_SUCCESS);
		poll_en <= 1'b0;
		wait_exp();
		chk_st(ST_ESTAB);
		wait_exp();
		poll_en <= 1'b1;
		put_attr(AT_WDT, 48'h1, GS_SUCCESS);
		poll_en <= 1'b0;
		wait_exp();
		chk_st(ST_NONEXIST);
		apb(1'b0, 8'h1c, 32'h0, q);
		chk({47'h0, err}, 48'h1, "unmapped error");
		chk({16'h0, q}, 48'h0, "unmapped data");
		chk({47'h0, pready}, 48'h1, "ready level");
		apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ALLOC_BIT, q);
		get_attr(AT_PPATH, 48'h03_30_02_24_04_20);
		get_attr(AT_WDT, 48'h0);
		svc(SVC_RESET, INST_POLL, 8'h00, 48'h0);
		chk({40'h0, code}, {40'h0, GS_CONFLICT}, "reset while configuring");
		svc(8'h4b, INST_POLL, AT_STATE, 48'h0);
		chk({40'h0, code}, {40'h0, GS_UNSUP}, "unknown service");
		put_attr(AT_CSIZE, {32'h0, CSZ}, GS_NOT_SET);
		apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_DELETE_BIT, q);
		@(posedge pclk);
		chk_st(ST_NONEXIST);
		stop_test();
	end
endmodule
`default_nettype wire

// File: src/pio_conn.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pio_conn #(
	parameter int CYC_PER_TICK = pio_pkg::CYC_PER_TICK
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               conn_id_ready,
	input  wire logic [15:0]        produced_conn_id,
	input  wire logic [15:0]        consumed_conn_id,
	input  wire logic [15:0]        produce_obj_size,
	input  wire logic [15:0]        consume_obj_size,
	input  wire logic               rx_activity,
	output pio_pkg::pio_state_t     conn_state,
	output logic      [3:0]         produce_group,
	output logic      [3:0]         consume_group,
	output logic                    watchdog_expired
);
	import pio_pkg::*;

	// the tick counter is 20 bits wide
	if (CYC_PER_TICK < 2 || CYC_PER_TICK > 1048576) begin : g_bad_tick
		$error("CYC_PER_TICK out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]  tct;
	logic [7:0]  icc;
	logic [15:0] interval;
	logic [7:0]  wdt_action;
	logic [47:0] ppath;
	logic [47:0] cpath;
	logic [31:0] arg_lo;
	logic [15:0] arg_hi;
	pio_cmd_t    cmd;
	pio_resp_t   resp;
	pio_resp_t   next_resp;
	logic        set_ok;
	logic        cmd_fire;
	logic        ctrl_fire;
	logic        do_alloc;
	logic        do_delete;
	logic [19:0] tick_cnt;
	logic [15:0] ms_cnt;
	logic        wd_run;
	logic        wd_restart;
	logic [47:0] arg;
	pio_cmd_t    wcmd;

	assign arg       = {arg_hi, arg_lo};
	assign wcmd      = pio_cmd_t'(pwdata);
	assign pready    = 1'b1;
	assign cmd_fire  = psel && penable && pwrite && paddr == ADDR_CMD;
	assign ctrl_fire = psel && penable && pwrite && paddr == ADDR_CTRL;
	assign do_alloc  = ctrl_fire && pwdata[CTRL_ALLOC_BIT];
	assign do_delete = ctrl_fire && pwdata[CTRL_DELETE_BIT];

	// attributes that this instance answers for
	function automatic logic attr_known(input logic [7:0] a);
		case (a)
			AT_STATE, AT_TYPE, AT_TCT, AT_PROD_ID, AT_CONS_ID, AT_ICC,
			AT_PSIZE, AT_CSIZE, AT_INTERVAL, AT_WDT, AT_PLEN, AT_PPATH,
			AT_CLEN, AT_CPATH: attr_known = 1'b1;
			default:           attr_known = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb decode and read data
	always_comb begin
		case (paddr)
			ADDR_CMD, ADDR_ARG_LO, ADDR_ARG_HI, ADDR_RESP_LO,
			ADDR_RESP_HI, ADDR_STATUS, ADDR_CTRL: pslverr = 1'b0;
			default:                              pslverr = psel && penable;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_CMD:     prdata <= cmd;
				ADDR_ARG_LO:  prdata <= arg_lo;
				ADDR_ARG_HI:  prdata <= {16'h0000, arg_hi};
				ADDR_RESP_LO: prdata <= resp.data[31:0];
				ADDR_RESP_HI: prdata <= {16'h0000, resp.data[47:32]};
				ADDR_STATUS:  prdata <= {8'h00, resp.len, resp.code, 5'h00, conn_state};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg_lo <= 32'h0000_0000;
			arg_hi <= 16'h0000;
		end else if (psel && penable && pwrite) begin
			if (paddr == ADDR_ARG_LO) begin
				arg_lo <= pwdata;
			end
			if (paddr == ADDR_ARG_HI) begin
				arg_hi <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// service interpreter
	always_comb begin
		next_resp = '{code: GS_SUCCESS, len: 8'h00, data: 48'h0};
		set_ok    = 1'b0;
		if (wcmd.inst == INST_CLASS) begin
			next_resp.code = GS_UNSUP;
		end else if (wcmd.inst != INST_POLL || conn_state == ST_NONEXIST) begin
			next_resp.code = GS_NO_OBJ;
		end else begin
			case (wcmd.svc)
				SVC_GET: begin
					if (!attr_known(wcmd.attr)) begin
						next_resp.code = GS_ATTR_NONE;
					end else begin
						next_resp.len = 8'h02;
						case (wcmd.attr)
							AT_STATE:    next_resp.data = {45'h0, conn_state};
							AT_TYPE:     next_resp.data = {40'h0, TYPE_IO};
							AT_TCT:      next_resp.data = {40'h0, tct};
							AT_PROD_ID:  next_resp.data = {32'h0, produced_conn_id};
							AT_CONS_ID:  next_resp.data = {32'h0, consumed_conn_id};
							AT_ICC:      next_resp.data = {40'h0, icc};
							AT_PSIZE:    next_resp.data = {32'h0, produce_obj_size};
							AT_CSIZE:    next_resp.data = {32'h0, consume_obj_size};
							AT_INTERVAL: next_resp.data = {32'h0, interval};
							AT_WDT:      next_resp.data = {40'h0, wdt_action};
							AT_PPATH:    next_resp.data = ppath;
							AT_CPATH:    next_resp.data = cpath;
							default:     next_resp.data = {32'h0, PATH_LEN};
						endcase
						case (wcmd.attr)
							AT_STATE, AT_TYPE, AT_TCT, AT_ICC, AT_WDT: next_resp.len = 8'h01;
							AT_PPATH, AT_CPATH: next_resp.len = PATH_LEN[7:0];
							default:            next_resp.len = 8'h02;
						endcase
					end
				end
				SVC_SET: begin
					if (!attr_known(wcmd.attr)) begin
						next_resp.code = GS_ATTR_NONE;
					end else begin
						case (wcmd.attr)
							AT_TCT, AT_PSIZE, AT_PPATH, AT_CPATH: begin
								if (conn_state != ST_CONFIG) begin
									next_resp.code = GS_CONFLICT;
								end else if (wcmd.attr == AT_TCT &&
								             arg[TCT_CLASS_LSB +: 4] == TCT_CLASS_RSVD) begin
									next_resp.code = GS_INVALID;
								end else if (wcmd.attr == AT_PSIZE &&
								             arg[15:0] != produce_obj_size) begin
									next_resp.code = GS_INVALID;
								end else begin
									set_ok = 1'b1;
								end
							end
							AT_INTERVAL: set_ok = 1'b1;
							AT_WDT: begin
								if (arg[7:0] >= WDA_DEFERRED) begin
									next_resp.code = GS_INVALID;
								end else begin
									set_ok = 1'b1;
								end
							end
							default: next_resp.code = GS_NOT_SET;
						endcase
					end
				end
				SVC_RESET: begin
					if (conn_state != ST_ESTAB && conn_state != ST_TIMEDOUT) begin
						next_resp.code = GS_CONFLICT;
					end
				end
				default: next_resp.code = GS_UNSUP;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd  <= '0;
			resp <= '0;
		end else if (cmd_fire) begin
			cmd  <= wcmd;
			resp <= next_resp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// attribute store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tct        <= TCT_RESET;
			icc        <= ICC_RESET;
			interval   <= INTERVAL_RESET;
			wdt_action <= WDT_RESET;
			ppath      <= PPATH_RESET;
			cpath      <= CPATH_RESET;
		end else if (do_alloc) begin
			tct        <= TCT_RESET;
			icc        <= ICC_RESET;
			interval   <= INTERVAL_RESET;
			wdt_action <= WDT_RESET;
			ppath      <= PPATH_RESET;
			cpath      <= CPATH_RESET;
		end else if (cmd_fire && wcmd.svc == SVC_SET && set_ok) begin
			case (wcmd.attr)
				AT_TCT:      tct        <= arg[7:0];
				AT_INTERVAL: interval   <= arg[15:0];
				AT_WDT:      wdt_action <= arg[7:0];
				AT_PPATH:    ppath      <= arg;
				AT_CPATH:    cpath      <= arg;
				default:     tct        <= tct;
			endcase
		end
	end

	assign produce_group = icc[7:4];
	assign consume_group = icc[3:0];

	////////////////////////////////////////////////////////////////////////////
	// inactivity watchdog, counted in milliseconds
	logic svc_reset_ok;
	logic interval_set;
	assign svc_reset_ok = cmd_fire && wcmd.svc == SVC_RESET && next_resp.code == GS_SUCCESS;
	assign interval_set = cmd_fire && wcmd.svc == SVC_SET && set_ok && wcmd.attr == AT_INTERVAL;
	assign wd_run       = conn_state == ST_ESTAB && interval != 16'h0000;
	assign wd_restart   = rx_activity || svc_reset_ok || interval_set;
	// ms_cnt counts whole milliseconds already elapsed, so the last one ends at interval - 1
	assign watchdog_expired = wd_run && !wd_restart && ms_cnt == interval - 16'h0001 &&
	                          tick_cnt == 20'(CYC_PER_TICK - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 20'h00000;
			ms_cnt   <= 16'h0000;
		end else if (!wd_run || wd_restart || watchdog_expired) begin
			tick_cnt <= 20'h00000;
			ms_cnt   <= 16'h0000;
		end else if (tick_cnt == 20'(CYC_PER_TICK - 1)) begin
			tick_cnt <= 20'h00000;
			ms_cnt   <= ms_cnt + 16'h0001;
		end else begin
			tick_cnt <= tick_cnt + 20'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// connection state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conn_state <= ST_NONEXIST;
		end else if (do_alloc) begin
			conn_state <= ST_CONFIG;
		end else if (do_delete) begin
			conn_state <= ST_NONEXIST;
		end else if (svc_reset_ok) begin
			conn_state <= ST_ESTAB;
		end else if (interval_set && conn_state == ST_CONFIG) begin
			conn_state <= conn_id_ready ? ST_ESTAB : ST_WAIT_ID;
		end else if (watchdog_expired) begin
			case (wdt_action)
				WDA_TIMEOUT: conn_state <= ST_TIMEDOUT;
				WDA_DELETE:  conn_state <= ST_NONEXIST;
				WDA_RESTART: conn_state <= ST_ESTAB;
				default:     conn_state <= ST_NONEXIST;
			endcase
		end else begin
			case (conn_state)
				ST_WAIT_ID: conn_state <= conn_id_ready ? ST_ESTAB : ST_WAIT_ID;
				ST_DEFERRED: conn_state <= ST_NONEXIST;
				default:    conn_state <= conn_state;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_interval_set_cfg;
		interval_set && conn_state == ST_CONFIG && !do_alloc && !do_delete;
	endsequence

	sequence s_expire_with(logic [7:0] act);
		watchdog_expired && wdt_action == act && !ctrl_fire && !cmd_fire;
	endsequence

	a_interval_establish: assert property (
		s_interval_set_cfg ##0 conn_id_ready |=> conn_state == ST_ESTAB)
		else $error("interval write did not establish");
	a_interval_wait_id: assert property (
		s_interval_set_cfg ##0 !conn_id_ready |=> conn_state == ST_WAIT_ID)
		else $error("interval write without ids did not wait");
	a_alloc_defaults: assert property (
		do_alloc |=> conn_state == ST_CONFIG && wdt_action == WDA_TIMEOUT &&
		ppath == PPATH_RESET && cpath == CPATH_RESET)
		else $error("allocation defaults wrong");
	a_cfg_lock: assert property (
		cmd_fire && wcmd.svc == SVC_SET && wcmd.inst == INST_POLL &&
		(wcmd.attr == AT_PPATH || wcmd.attr == AT_TCT) && conn_state == ST_ESTAB
		|=> resp.code == GS_CONFLICT && $stable(ppath) && $stable(tct))
		else $error("configurable attribute changed outside configuring");
	a_action3_refused: assert property (
		cmd_fire && wcmd.svc == SVC_SET && wcmd.attr == AT_WDT &&
		wcmd.inst == INST_POLL && conn_state != ST_NONEXIST && arg[7:0] == WDA_DEFERRED
		|=> resp.code == GS_INVALID && wdt_action != WDA_DEFERRED)
		else $error("timeout action 3 accepted");
	a_expire_timeout: assert property (
		s_expire_with(WDA_TIMEOUT) |=> conn_state == ST_TIMEDOUT [*2])
		else $error("expiry with action 0 did not time out");
	a_expire_delete: assert property (
		s_expire_with(WDA_DELETE) |=> conn_state == ST_NONEXIST)
		else $error("expiry with action 1 did not delete");
	a_expire_restart: assert property (
		s_expire_with(WDA_RESTART) |=> conn_state == ST_ESTAB && ms_cnt == 16'h0000)
		else $error("expiry with action 2 did not restart");
	a_reset_service: assert property (
		svc_reset_ok && !ctrl_fire |=> conn_state == ST_ESTAB && tick_cnt == 20'h00000)
		else $error("reset service did not re-establish");
	a_class_refused: assert property (
		cmd_fire && wcmd.inst == INST_CLASS |=> resp.code == GS_UNSUP)
		else $error("class instance service not refused");
	a_no_deferred: assert property (
		conn_state != ST_DEFERRED)
		else $error("deferred delete entered on an I/O connection");
	a_path_length: assert property (
		cmd_fire && wcmd.svc == SVC_GET && wcmd.inst == INST_POLL &&
		conn_state != ST_NONEXIST && (wcmd.attr == AT_PLEN || wcmd.attr == AT_CLEN)
		|=> resp.data == 48'(PATH_LEN) && resp.code == GS_SUCCESS)
		else $error("path length not six");
	a_nonexist_code: assert property (
		do_delete && !do_alloc |=> conn_state == ST_NONEXIST ##1 conn_state != ST_WAIT_ID)
		else $error("deleted connection did not report state 0");
endmodule
`default_nettype wire
